// file: drive_model.sv
// Purpose: drive control partner that ramps the motor down
// Assumes: speed changes by one ramp step a clock
// Notes: full speed returns on reset or when modulation is handed back
`timescale 1ns/10ps
module drive_model #(parameter logic [15:0] TOP_SPEED = 16'h03E8, OWN_DECEL = 16'h0004) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire stop_pkg::drive_cmd_t drive_cmd,
   input wire logic sto,
   output logic [15:0] motor_speed
);
   logic [15:0] step;
   // Zero profile deceleration hands the ramp to the drive's own setting
   assign step = drive_cmd.use_own_ramp ? OWN_DECEL : drive_cmd.ramp_decel;
   // Ramp down on request; torque off or withdrawn modulation also lets speed fall
   always_ff @(posedge sys_clk) begin
      if (sys_rst || (drive_cmd.modulate_ok && !drive_cmd.ramp_req && !sto)) begin
         motor_speed <= TOP_SPEED;
      end else begin
         motor_speed <= (motor_speed > step) ? motor_speed - step : 16'h0000;
      end
   end
endmodule

// file: ramp_monitored_stop.sv
// Purpose: ramp monitored safe stop with speed limit activated brake
// Assumes: inputs synchronous to sys_clk; speed is a speed magnitude
// Notes: encoder_mode is static; change it only while idle
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`include "stop_cfg.svh"
module ramp_monitored_stop (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic stop_req,
   input wire logic stop_ack,
   input wire logic encoder_mode,
   input wire logic [15:0] motor_speed,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic stop_state_o,
   output logic stop_done_o,
   output logic sto_o,
   output logic brake_o,
   output logic ramp_monitor_o,
   output stop_pkg::drive_cmd_t drive_cmd_o,
   output logic irq
);
   typedef struct packed {
      stop_pkg::seq_state_t st;
      stop_pkg::cfg_t cfg;
      stop_pkg::ind_t ind;
      stop_pkg::drive_cmd_t cmd;
      logic [`TICK_W-1:0] tick;
      logic [15:0] ms;
      logic [`IRQ_W-1:0] irq_st;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic acc;
   logic wr;
   logic [`IRQ_W-1:0] ev;
   logic ms_tick;
   logic [15:0] lead_ms;

   assign acc = psel & penable & ~s_r.pready;
   assign wr = acc & pwrite;
   assign ms_tick = (s_r.tick == `TICK_W'(`MS_TICKS - 1));
   // Magnitude of a negative brake lead delay
   assign lead_ms = 16'(~s_r.cfg.brake_delay + 16'h0001);

   always_comb begin
      s_nxt = s_r;
      ev = '0;
      s_nxt.pready = acc;
      s_nxt.pslverr = 1'b0;
      // Millisecond prescaler; restarted on stop request, at the brake limit and at brake activation
      s_nxt.tick = ms_tick ? '0 : `TICK_W'(s_r.tick + 1'b1);
      if (ms_tick) begin
         s_nxt.ms = 16'(s_r.ms + 16'h0001);
      end
      // APB writes of configuration; one wait state per access
      if (wr) begin
         case (paddr)
            `OFS_RESP_TIME: s_nxt.cfg.resp_time = pwdata[15:0];
            `OFS_RAMP_DECEL: s_nxt.cfg.ramp_decel = pwdata[15:0];
            `OFS_RAMP_UPPER: s_nxt.cfg.ramp_upper = pwdata[15:0];
            `OFS_RAMP_LOWER: s_nxt.cfg.ramp_lower = pwdata[15:0];
            `OFS_BRAKE_SPEED: s_nxt.cfg.brake_speed = pwdata[15:0];
            `OFS_ZERO_SPEED: s_nxt.cfg.zero_speed = pwdata[15:0];
            `OFS_BRAKE_DELAY: s_nxt.cfg.brake_delay = pwdata[15:0];
            `OFS_EXTRA_DELAY: s_nxt.cfg.extra_delay = pwdata[15:0];
            `OFS_TIME_TO_ZERO: s_nxt.cfg.time_to_zero = pwdata[15:0];
            `OFS_IRQ_ENABLE: s_nxt.cfg.irq_en = pwdata[`IRQ_W-1:0];
            `OFS_IRQ_CLEAR: s_nxt.irq_st = s_r.irq_st & ~pwdata[`IRQ_W-1:0];
            `OFS_CTRL, `OFS_STATUS, `OFS_IRQ_STATUS: ;
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // Reads
      s_nxt.prdata = 32'h00000000;
      if (acc & ~pwrite) begin
         case (paddr)
            `OFS_CTRL: s_nxt.prdata = {31'h00000000, encoder_mode};
            `OFS_RESP_TIME: s_nxt.prdata = {16'h0000, s_r.cfg.resp_time};
            `OFS_RAMP_DECEL: s_nxt.prdata = {16'h0000, s_r.cfg.ramp_decel};
            `OFS_RAMP_UPPER: s_nxt.prdata = {16'h0000, s_r.cfg.ramp_upper};
            `OFS_RAMP_LOWER: s_nxt.prdata = {16'h0000, s_r.cfg.ramp_lower};
            `OFS_BRAKE_SPEED: s_nxt.prdata = {16'h0000, s_r.cfg.brake_speed};
            `OFS_ZERO_SPEED: s_nxt.prdata = {16'h0000, s_r.cfg.zero_speed};
            `OFS_BRAKE_DELAY: s_nxt.prdata = {16'h0000, s_r.cfg.brake_delay};
            `OFS_EXTRA_DELAY: s_nxt.prdata = {16'h0000, s_r.cfg.extra_delay};
            `OFS_TIME_TO_ZERO: s_nxt.prdata = {16'h0000, s_r.cfg.time_to_zero};
            `OFS_STATUS: s_nxt.prdata = {25'h0000000, s_r.st, s_r.ind.stop_state,
               s_r.ind.stop_done, s_r.ind.sto_active, s_r.ind.brake_on};
            `OFS_IRQ_STATUS: s_nxt.prdata = {27'h0000000, s_r.irq_st};
            `OFS_IRQ_ENABLE: s_nxt.prdata = {27'h0000000, s_r.cfg.irq_en};
            `OFS_IRQ_CLEAR: s_nxt.prdata = 32'h00000000;
            default: s_nxt.pslverr = 1'b1;
         endcase
      end

      // Ramp monitoring: any crossing trips torque off at once
      if (s_r.ind.ramp_monitor &&
          (motor_speed > s_r.cfg.ramp_upper || motor_speed < s_r.cfg.ramp_lower)) begin
         s_nxt.ind.sto_active = 1'b1;
         s_nxt.ind.ramp_trip = 1'b1;
         s_nxt.ind.ramp_monitor = 1'b0;
         s_nxt.cmd.modulate_ok = 1'b0;
         ev[2] = ~s_r.ind.ramp_trip;
      end

      // Sequencer
      case (s_r.st)
         stop_pkg::ST_IDLE: begin
            if (stop_req) begin
               s_nxt.st = stop_pkg::ST_RESPONSE;
               s_nxt.ind.stop_state = 1'b1;
               s_nxt.tick = '0;
               s_nxt.ms = 16'h0000;
               ev[0] = 1'b1;
            end
         end
         stop_pkg::ST_RESPONSE: begin
            if (s_r.ms >= s_r.cfg.resp_time) begin
               s_nxt.st = stop_pkg::ST_RAMP;
               s_nxt.cmd.ramp_req = 1'b1;
               s_nxt.cmd.ramp_decel = s_r.cfg.ramp_decel;
               s_nxt.cmd.use_own_ramp = (s_r.cfg.ramp_decel == 16'h0000);
               s_nxt.ind.ramp_monitor = ~s_r.ind.ramp_trip;
            end
         end
         stop_pkg::ST_RAMP: begin
            if (motor_speed < s_r.cfg.brake_speed) begin
               s_nxt.st = stop_pkg::ST_EXTRA;
               s_nxt.tick = '0;
               s_nxt.ms = 16'h0000;
               if (!encoder_mode) begin
                  s_nxt.ind.ramp_monitor = 1'b0;
               end
            end
         end
         stop_pkg::ST_EXTRA: begin
            if (s_r.ms >= s_r.cfg.extra_delay) begin
               s_nxt.ind.brake_on = 1'b1;
               s_nxt.tick = '0;
               s_nxt.ms = 16'h0000;
               ev[1] = 1'b1;
               if (s_r.cfg.brake_delay[15]) begin
                  s_nxt.st = stop_pkg::ST_LEAD;
               end else begin
                  s_nxt.st = stop_pkg::ST_STOPPING;
                  s_nxt.ind.sto_active = 1'b1;
                  s_nxt.cmd.modulate_ok = 1'b0;
               end
            end
         end
         stop_pkg::ST_LEAD: begin
            if (s_r.ms >= lead_ms) begin
               s_nxt.st = stop_pkg::ST_STOPPING;
               s_nxt.ind.sto_active = 1'b1;
               s_nxt.cmd.modulate_ok = 1'b0;
            end
         end
         stop_pkg::ST_STOPPING: begin
            // Time-to-zero runs from brake activation, so lead time counts too
            if (s_r.ms >= s_r.cfg.time_to_zero && !encoder_mode) begin
               s_nxt.st = stop_pkg::ST_DONE;
               s_nxt.ind.stop_done = 1'b1;
               ev[3] = 1'b1;
            end
         end
         stop_pkg::ST_DONE: begin
            if (stop_ack && !stop_req) begin
               s_nxt.st = stop_pkg::ST_IDLE;
               s_nxt.ind = '0;
               s_nxt.cmd.ramp_req = 1'b0;
               s_nxt.cmd.use_own_ramp = 1'b0;
               s_nxt.cmd.modulate_ok = 1'b1;
               ev[4] = 1'b1;
            end
         end
         default: begin
            s_nxt.st = stop_pkg::ST_IDLE;
         end
      endcase

      // Encoder variant completes on zero speed once braking is under way
      if (encoder_mode && (s_r.st == stop_pkg::ST_STOPPING || s_r.st == stop_pkg::ST_LEAD)
          && motor_speed <= s_r.cfg.zero_speed) begin
         s_nxt.ind.stop_done = 1'b1;
         s_nxt.ind.ramp_monitor = 1'b0;
         ev[3] = ~s_r.ind.stop_done;
         if (s_r.st == stop_pkg::ST_STOPPING) begin
            s_nxt.st = stop_pkg::ST_DONE;
         end
      end

      // Sticky events; a new event wins over a clear in the same cycle
      s_nxt.irq_st = s_nxt.irq_st | ev;
      s_nxt.irq = |(s_r.irq_st & s_r.cfg.irq_en);
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.st <= stop_pkg::ST_IDLE;
         s_r.cfg.brake_speed <= `RST_SPEED;
         s_r.cmd.modulate_ok <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign stop_state_o = s_r.ind.stop_state;
   assign stop_done_o = s_r.ind.stop_done;
   assign sto_o = s_r.ind.sto_active;
   assign brake_o = s_r.ind.brake_on;
   assign ramp_monitor_o = s_r.ind.ramp_monitor;
   assign drive_cmd_o = s_r.cmd;
   assign irq = s_r.irq;
endmodule

// file: ramp_stop_assertions.sv
// Purpose: port checks of the ramp monitored stop
// Assumes: limits shadowed from completed APB writes
// Notes: shadow lags one cycle, so limits are set before a stop
`timescale 1ns/10ps
`include "stop_cfg.svh"
module ramp_stop_checker (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic stop_req,
   input wire logic stop_ack,
   input wire logic encoder_mode,
   input wire logic [15:0] motor_speed,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic stop_state_o,
   input wire logic stop_done_o,
   input wire logic sto_o,
   input wire logic brake_o,
   input wire logic ramp_monitor_o,
   input wire stop_pkg::drive_cmd_t drive_cmd_o
);
   logic [15:0] hi_r, lo_r, bspd_r, zspd_r, dly_r;
   // Shadow of the limits the sequencer compares against
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {hi_r, lo_r, bspd_r, zspd_r, dly_r} <= '0;
      end else if (psel && penable && pready && pwrite) begin
         case (paddr)
            `OFS_RAMP_UPPER: hi_r <= pwdata[15:0];
            `OFS_RAMP_LOWER: lo_r <= pwdata[15:0];
            `OFS_BRAKE_SPEED: bspd_r <= pwdata[15:0];
            `OFS_ZERO_SPEED: zspd_r <= pwdata[15:0];
            `OFS_BRAKE_DELAY: dly_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   stop_entry_a: assert property (stop_req && !stop_state_o |=> stop_state_o)
      else $error("stop state late");
   state_hold_a: assert property (stop_state_o && !(stop_ack && stop_done_o && !stop_req)
      |=> stop_state_o) else $error("stop state dropped");
   release_all_a: assert property (stop_ack && stop_done_o && !stop_req |=> !stop_state_o
      && !stop_done_o && !sto_o && !brake_o && drive_cmd_o.modulate_ok) else $error("release");
   ramp_mon_a: assert property ($rose(drive_cmd_o.ramp_req) |-> ramp_monitor_o)
      else $error("monitor not started");
   own_ramp_a: assert property (drive_cmd_o.ramp_req |-> drive_cmd_o.use_own_ramp
      == (drive_cmd_o.ramp_decel == 16'h0000)) else $error("ramp select");
   ramp_trip_a: assert property (ramp_monitor_o && (motor_speed > hi_r || motor_speed < lo_r)
      |-> ##[1:2] sto_o) else $error("no trip");
   brake_sto_a: assert property ($rose(brake_o) && !dly_r[15] |-> sto_o)
      else $error("torque off not with brake");
   brake_lead_a: assert property ($rose(brake_o) && dly_r[15] && !$past(sto_o)
      |-> !sto_o [*8]) else $error("torque off early");
   mon_end_a: assert property (!encoder_mode && ramp_monitor_o && !sto_o
      && motor_speed < bspd_r |-> ##[1:2] !ramp_monitor_o) else $error("monitor kept");
   zero_done_a: assert property (encoder_mode && brake_o && !stop_done_o
      && motor_speed <= zspd_r |-> ##[1:3] stop_done_o && !ramp_monitor_o) else $error("zero");
endmodule

// file: stop_cfg.svh
// Purpose: constants for the ramp monitored safe stop with brake sequencer
// Assumes: sys_clk at 250 MHz, all times in milliseconds at the APB registers
// Notes: offsets are byte addresses of aligned 32-bit words
// How it works
// - Stop request raises stop-state until acknowledged release
// - After response time, drive ramps along profile
// - Zero profile deceleration selects drive's own ramp
// - Ramp start begins speed limit monitoring
// - Ramp limit crossing trips torque off immediately
// - Speed below brake limit triggers brake handling
// - Without encoder, monitoring ends at brake limit
// - Non-negative delay: brake and torque off together
// - Negative delay: torque off after delay magnitude
// - Torque-off indication rises with torque off
// - Optional extra delay before brake and torque off
// - Without encoder, time-to-zero starts at brake
// - Without encoder, time-to-zero expiry asserts stop completed
// - With encoder, zero speed completes and ends monitoring
// - Acknowledge only after completion and request withdrawn
// - Valid acknowledge releases everything, clears indications
`ifndef STOP_CFG_SVH
`define STOP_CFG_SVH
`define OFS_CTRL 12'h000
`define OFS_RESP_TIME 12'h004
`define OFS_RAMP_DECEL 12'h008
`define OFS_RAMP_UPPER 12'h00C
`define OFS_RAMP_LOWER 12'h010
`define OFS_BRAKE_SPEED 12'h014
`define OFS_ZERO_SPEED 12'h018
`define OFS_BRAKE_DELAY 12'h01C
`define OFS_EXTRA_DELAY 12'h020
`define OFS_TIME_TO_ZERO 12'h024
`define OFS_STATUS 12'h028
`define OFS_IRQ_STATUS 12'h02C
`define OFS_IRQ_ENABLE 12'h030
`define OFS_IRQ_CLEAR 12'h034
`define CLK_MHZ 250
`define MS_TICKS (`CLK_MHZ * 1000)
`define TICK_W 18
`define RST_SPEED 16'h0000
`define IRQ_W 5
`endif

// file: stop_pkg.sv
// Purpose: types for the ramp monitored safe stop sequencer
// Assumes: constants come from stop_cfg.svh
// Notes: speeds are unsigned magnitudes, delays in ms
package stop_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RESPONSE = 3'b001,
      ST_RAMP = 3'b010,
      ST_EXTRA = 3'b011,
      ST_LEAD = 3'b100,
      ST_STOPPING = 3'b101,
      ST_DONE = 3'b110
   } seq_state_t;

   typedef struct packed {
      logic [15:0] resp_time;
      logic [15:0] ramp_decel;
      logic [15:0] ramp_upper;
      logic [15:0] ramp_lower;
      logic [15:0] brake_speed;
      logic [15:0] zero_speed;
      logic [15:0] brake_delay;
      logic [15:0] extra_delay;
      logic [15:0] time_to_zero;
      logic [4:0] irq_en;
   } cfg_t;

   typedef struct packed {
      logic ramp_req;
      logic use_own_ramp;
      logic [15:0] ramp_decel;
      logic modulate_ok;
   } drive_cmd_t;

   typedef struct packed {
      logic stop_state;
      logic stop_done;
      logic sto_active;
      logic brake_on;
      logic ramp_monitor;
      logic ramp_trip;
   } ind_t;
endpackage

// file: testbench.sv
// Purpose: scenario bench of the ramp monitored stop
// Assumes: times programmed as 0 ms, the s_lead brake delay aside, so steps follow at once
// Notes: negative delay is only watched for its first cycles
`timescale 1ns/10ps
`include "stop_cfg.svh"
module testbench;
   logic sys_clk = 1'b0, sys_rst = 1'b1, stop_req = 1'b0, stop_ack = 1'b0, encoder_mode = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic stop_state_o, stop_done_o, sto_o, brake_o, ramp_monitor_o, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] motor_speed;
   stop_pkg::drive_cmd_t drive_cmd_o;
   int miscompares = 0, num_checks = 0, cycles = 0;
   always #2 sys_clk = ~sys_clk;
   ramp_monitored_stop dut (.sys_clk, .sys_rst, .stop_req, .stop_ack, .encoder_mode,
      .motor_speed, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .stop_state_o, .stop_done_o, .sto_o, .brake_o, .ramp_monitor_o, .drive_cmd_o, .irq);
   drive_model drive (.sys_clk, .sys_rst, .drive_cmd(drive_cmd_o), .sto(sto_o), .motor_speed);
   // Watchdog against a hung wait
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_hi(ref logic s);
      while (s !== 1'b1) @(posedge sys_clk);
   endtask
   task automatic do_reset(input logic enc);
      stop_req <= 1'b0;
      encoder_mode <= enc;
      sys_rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask
   task automatic setup(input logic [15:0] decel, input logic [15:0] lo, input logic [15:0] dly);
      logic [15:0] v [9];
      v = '{16'h0000, decel, 16'hFFFF, lo, 16'h0064, 16'h000A, dly, 16'h0000, 16'h0000};
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, 12'(`OFS_RESP_TIME + 4 * i), {16'h0000, v[i]});
      end
      stop_req <= 1'b1;
   endtask
   task automatic release_seq;
      stop_ack <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("early ack", 1'b1, stop_state_o);
      stop_ack <= 1'b0;
      stop_req <= 1'b0;
      @(posedge sys_clk);
      stop_ack <= 1'b1;
      @(posedge sys_clk);
      stop_ack <= 1'b0;
      @(posedge sys_clk);
      chk("released", 5'h01, {stop_state_o, stop_done_o, sto_o, brake_o,
         drive_cmd_o.modulate_ok});
   endtask
   task automatic s_regs;
      chk("reset outs", 6'h01, {irq, stop_state_o, stop_done_o, sto_o, brake_o,
         drive_cmd_o.modulate_ok});
      apb(1'b1, `OFS_STATUS, 32'h0000000F);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status ro", 32'h0, rd);
      chk("status err", 1'b0, err);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
   endtask
   task automatic s_time;
      setup(16'h0014, 16'h0000, 16'h0000);
      wait_hi(ramp_monitor_o);
      chk("ramp cmd", 18'h20014, {drive_cmd_o.ramp_req, drive_cmd_o.use_own_ramp,
         drive_cmd_o.ramp_decel});
      wait_hi(brake_o);
      chk("sto with brake", 1'b1, sto_o);
      wait_hi(stop_done_o);
      release_seq();
      chk("masked irq", 1'b0, irq);
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk("irq status", 32'h0000001B, rd);
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h0000001F);
      repeat (2) @(posedge sys_clk);
      chk("irq on", 1'b1, irq);
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h0000001F);
      repeat (2) @(posedge sys_clk);
      chk("irq off", 1'b0, irq);
   endtask
   task automatic s_enc;
      do_reset(1'b1);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk("ctrl", 32'h1, rd);
      setup(16'h0000, 16'h0000, 16'h0000);
      wait_hi(ramp_monitor_o);
      chk("own ramp", 1'b1, drive_cmd_o.use_own_ramp);
      wait_hi(stop_done_o);
      chk("zero speed", 2'b11, {brake_o, motor_speed <= 16'h000A});
      release_seq();
   endtask
   task automatic s_trip;
      do_reset(1'b0);
      setup(16'h0014, 16'h0384, 16'h0000);
      wait_hi(sto_o);
      chk("trip", 2'b01, {brake_o, motor_speed > 16'h0064});
   endtask
   task automatic s_lead;
      do_reset(1'b0);
      setup(16'h0014, 16'h0000, 16'hFFFF);
      wait_hi(brake_o);
      repeat (100) @(posedge sys_clk);
      chk("brake leads", 1'b0, sto_o);
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Scenarios in order; s_time runs on from s_regs, the others each from their own reset
   initial begin
      do_reset(1'b0);
      s_regs();
      s_time();
      s_enc();
      s_trip();
      s_lead();
      tally_and_finish();
   end
endmodule
bind ramp_monitored_stop ramp_stop_checker chk_i (.sys_clk, .sys_rst, .stop_req, .stop_ack,
   .encoder_mode, .motor_speed, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .stop_state_o, .stop_done_o, .sto_o, .brake_o, .ramp_monitor_o, .drive_cmd_o);
